// [hw/slot_remap_config_control.sv]
// Purpose: loads, checks and keeps the slot remap record; maps io accesses
// Assumes: record bytes arrive one per recStrobe; retentive map survives
//          a restart because only reset_n clears it
// Notes:   a record is closed by recLast on its final byte
module slot_remap_config_control
  import slot_remap_pkg::*;
#(
  parameter int SLOTS = 32
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        remapEnable,
  input  wire logic        commModulePresent,
  input  wire logic [4:0]  presetLastSlot,
  input  wire logic        startupRequest,
  input  wire logic        startupEnd,
  input  wire logic        recStart,
  input  wire logic        recStrobe,
  input  wire logic        recLast,
  input  wire logic [7:0]  recData,
  input  wire logic [15:0] recHwId,
  input  wire logic        recInStartup,
  output logic             recDone,
  output logic [15:0]      recStatus,
  output logic             loadRefused,
  output logic             running,
  output logic             ioInitialized,
  output logic             stopLogged,
  output logic             memResetPulse,
  input  wire logic        accValid,
  input  wire logic [4:0]  accCfgSlot,
  input  wire logic        accWrite,
  input  wire logic        accRecord,
  input  wire logic [31:0] accWdata,
  input  wire logic [31:0] ioRdata,
  output logic             ioValid,
  output logic [4:0]       ioRealSlot,
  output logic [31:0]      ioWdata,
  output logic [31:0]      accRdata,
  output logic             accError,
  input  wire logic        diagValid,
  input  wire logic [4:0]  diagRealSlot,
  output logic             diagOut,
  output logic [4:0]       diagCfgSlot
);

  initial begin
    if (SLOTS != 32) $error("SLOTS must be 32");
  end

  // ==========================================================================
  // record parser
  parse_state_t stQ;
  logic [7:0]   lenQ;
  logic [7:0]   idxQ;
  logic         badHdrQ;
  logic         badParQ;
  logic [SLOTS-1:0] usedQ;
  logic [7:0]   newMapQ [SLOTS];
  logic [7:0]   mapQ    [SLOTS];
  logic         validQ;
  logic         changed;
  logic [15:0]  verdict;
  logic [7:0]   entryIdx;
  logic         inLayout;

  assign entryIdx = idxQ - HDR_LEN;
  assign inLayout = (entryIdx <= {3'h0, presetLastSlot});

  // walk the bytes, checking header and entries as they pass
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stQ     <= ST_IDLE;
      lenQ    <= 8'h00;
      idxQ    <= 8'h00;
      badHdrQ <= 1'b0;
      badParQ <= 1'b0;
      usedQ   <= '0;
    end else if (recStart) begin
      stQ     <= ST_HDR;
      idxQ    <= 8'h00;
      badHdrQ <= 1'b0;
      badParQ <= 1'b0;
      usedQ   <= '0;
    end else if (recStrobe && (stQ == ST_HDR || stQ == ST_BODY)) begin
      idxQ <= idxQ + 8'h01;
      if (idxQ == 8'h00) lenQ <= recData;
      if ((idxQ == 8'h01 && recData != REC_ID) ||
          (idxQ == 8'h02 && recData != REC_VERSION) ||
          (idxQ == 8'h03 && recData != REC_PAD))
        badParQ <= 1'b1;
      if (idxQ >= HDR_LEN && inLayout) begin
        if (recData != ENTRY_ABSENT) begin
          if (recData >= 8'(SLOTS))
            badParQ <= 1'b1;
          else if (usedQ[recData[4:0]])
            badParQ <= 1'b1;
          else
            usedQ[recData[4:0]] <= 1'b1;
        end
        if (entryIdx[4:0] == CPU_SLOT && recData != 8'(CPU_SLOT))
          badParQ <= 1'b1;
      end
      stQ <= recLast ? ST_DONE : ST_BODY;
    end else if (stQ == ST_DONE) begin
      stQ <= ST_IDLE;
    end
  end

  // capture incoming entries into the shadow map
  always_ff @(posedge core_clk) begin
    if (recStrobe && idxQ >= HDR_LEN && inLayout)
      newMapQ[entryIdx[4:0]] <= recData;
  end

  // verdict priority: context, enable, length, parameters
  always_comb begin
    verdict = ERR_NONE;
    if (!recInStartup)
      verdict = ERR_CONTEXT;
    else if (!remapEnable)
      verdict = ERR_NOT_ENABLE;
    else if (lenQ != idxQ ||
             idxQ < HDR_LEN + 8'h01 + {3'h0, presetLastSlot})
      verdict = ERR_LENGTH;
    else if (badParQ)
      verdict = ERR_PARAM;
  end

  // record addressed elsewhere is not ours to judge
  logic forUs;
  assign forUs = (recHwId == TARGET_HW_ID);

  // compare new map to stored one over the preset layout
  always_comb begin
    changed = !validQ;
    for (int i = 0; i < SLOTS; i++) begin
      if (i <= int'(presetLastSlot) && newMapQ[i] != mapQ[i])
        changed = 1'b1;
    end
  end

  // ==========================================================================
  // retentive map: only reset_n clears it
  // keep accepted record
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      validQ <= 1'b0;
      for (int i = 0; i < SLOTS; i++) mapQ[i] <= ENTRY_ABSENT;
    end else if (stQ == ST_DONE && forUs && verdict == ERR_NONE) begin
      validQ <= 1'b1;
      for (int i = 0; i < SLOTS; i++)
        mapQ[i] <= (i <= int'(presetLastSlot)) ? newMapQ[i] : ENTRY_ABSENT;
    end
  end

  // answer to the writer
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      recDone   <= 1'b0;
      recStatus <= ERR_NONE;
    end else begin
      recDone <= (stQ == ST_DONE) && forUs;
      if (stQ == ST_DONE && forUs) recStatus <= verdict;
    end
  end

  // ==========================================================================
  // operating phase
  phase_t phQ;
  logic   goodThisStartQ;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      phQ            <= PH_STOP;
      goodThisStartQ <= 1'b0;
      loadRefused    <= 1'b0;
      ioInitialized  <= 1'b0;
      stopLogged     <= 1'b0;
      memResetPulse  <= 1'b0;
    end else begin
      memResetPulse <= 1'b0;
      stopLogged    <= 1'b0;
      loadRefused <= remapEnable && commModulePresent;
      unique case (phQ)
        PH_STOP: begin
          if (startupRequest && !(remapEnable && commModulePresent)) begin
            phQ            <= PH_STARTUP;
            goodThisStartQ <= validQ;
          end
        end
        PH_STARTUP: begin
          if (stQ == ST_DONE && forUs && verdict == ERR_NONE) begin
            goodThisStartQ <= 1'b1;
            if (changed && validQ) begin
              memResetPulse  <= 1'b1;
              goodThisStartQ <= 1'b1;
            end
          end
          if (startupEnd) begin
            if (!remapEnable || goodThisStartQ) begin
              phQ           <= PH_RUN;
              ioInitialized <= 1'b1;
            end else begin
              phQ           <= PH_STOP;
              ioInitialized <= 1'b0;
              stopLogged    <= 1'b1;
            end
          end
        end
        PH_RUN: begin
          if (startupRequest) begin
            phQ            <= PH_STARTUP;
            goodThisStartQ <= validQ;
          end
        end
      endcase
    end
  end

  assign running = (phQ == PH_RUN);

  // ==========================================================================
  // io access mapping by configured slot
  logic [7:0] realEntry;
  logic       absent;
  assign realEntry = remapEnable ? mapQ[accCfgSlot] : {3'h0, accCfgSlot};
  assign absent    = (realEntry == ENTRY_ABSENT);

  assign ioValid    = accValid && !absent;
  assign ioRealSlot = realEntry[4:0];
  assign ioWdata    = accWdata;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      accRdata <= 32'h0000_0000;
      accError <= 1'b0;
    end else begin
      accRdata <= absent ? 32'h0000_0000 : ioRdata;
      accError <= accValid && absent && accRecord && !accWrite;
    end
  end

  // ==========================================================================
  // diagnostics translated back to configured slots
  logic       diagHit;
  logic [4:0] diagSlot;
  always_comb begin
    diagHit  = 1'b0;
    diagSlot = 5'h00;
    for (int i = 0; i < SLOTS; i++) begin
      if (!remapEnable && diagRealSlot == 5'(i)) begin
        diagHit  = 1'b1;
        diagSlot = 5'(i);
      end else if (remapEnable && mapQ[i] == {3'h0, diagRealSlot}) begin
        diagHit  = 1'b1;
        diagSlot = 5'(i);
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      diagOut     <= 1'b0;
      diagCfgSlot <= 5'h00;
    end else begin
      diagOut     <= diagValid && diagHit;
      diagCfgSlot <= diagSlot;
    end
  end

  // ==========================================================================
  // checks
  a_absent_write_drop: assert property (@(posedge core_clk)
    disable iff (!reset_n) accValid && absent |-> !ioValid)
    else $error("write reached absent module");

  a_absent_read_zero: assert property (@(posedge core_clk)
    disable iff (!reset_n) absent |=> accRdata == 32'h0000_0000)
    else $error("absent read not zero");

  a_record_read_err: assert property (@(posedge core_clk)
    disable iff (!reset_n) accValid && absent && accRecord && !accWrite
    |=> accError)
    else $error("absent record read gave no error");

  a_record_write_ok: assert property (@(posedge core_clk)
    disable iff (!reset_n) accValid && accWrite |=> !accError)
    else $error("write raised error");

  a_context_code: assert property (@(posedge core_clk)
    disable iff (!reset_n) stQ == ST_DONE && forUs && !recInStartup
    |=> recDone && recStatus == ERR_CONTEXT)
    else $error("wrong context code");

  a_enable_code: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    stQ == ST_DONE && forUs && recInStartup && !remapEnable
    |=> recStatus == ERR_NOT_ENABLE)
    else $error("not enabled code");

  a_startup_abort: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    phQ == PH_STARTUP && startupEnd && remapEnable && !goodThisStartQ
    |=> phQ == PH_STOP && stopLogged && !ioInitialized)
    else $error("startup not aborted");

  a_comm_refuse: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    phQ == PH_STOP && remapEnable && commModulePresent |=> phQ == PH_STOP)
    else $error("load with comm module");

endmodule

// [hw/slot_remap_pkg.sv]
// Purpose: constants shared by the slot remap configuration loader
// Assumes: one 250 MHz clock, byte-serial record input
// Notes:   error codes and record header layout
package slot_remap_pkg;

  // ==========================================================================
  // record header layout and codes
  localparam logic [7:0]  HDR_LEN        = 8'h04;  // header bytes
  localparam logic [7:0]  REC_ID         = 8'hc4;  // record number 196
  localparam logic [7:0]  REC_VERSION    = 8'h04;
  localparam logic [7:0]  REC_PAD        = 8'h00;
  localparam logic [7:0]  ENTRY_ABSENT   = 8'hff;
  localparam logic [15:0] TARGET_HW_ID   = 16'h0021; // hardware id 33
  localparam logic [4:0]  CPU_SLOT       = 5'h01;

  // ==========================================================================
  // status codes returned at the end of a record write
  localparam logic [15:0] ERR_NONE       = 16'h0000;
  localparam logic [15:0] ERR_LENGTH     = 16'h80b1;
  localparam logic [15:0] ERR_NOT_ENABLE = 16'h80b5;
  localparam logic [15:0] ERR_CONTEXT    = 16'h80e2;
  localparam logic [15:0] ERR_PARAM      = 16'h80b8;

  // ==========================================================================
  // record parser states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_HDR  = 4'b0010,
    ST_BODY = 4'b0100,
    ST_DONE = 4'b1000
  } parse_state_t;

  // operating phase of the controller
  typedef enum logic [2:0] {
    PH_STOP    = 3'b001,
    PH_STARTUP = 3'b010,
    PH_RUN     = 3'b100
  } phase_t;

endpackage

// [bench/io_rack_model.sv]
// Purpose: behavioural io modules sitting in the real rack slots
// Assumes: a read is answered in the same cycle it is forwarded
// Notes:   unselected data bus shows a pattern changing every cycle
module io_rack_model (
  input  wire logic        core_clk,
  input  wire logic        ioValid,
  input  wire logic [4:0]  ioRealSlot,
  output logic      [31:0] ioRdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [31:0] noise = 32'h1234abcd;

  // ==========================================================================
  // idle bus pattern, never a stale value
  always_ff @(posedge core_clk) begin
    noise <= noise + 32'h01010101;
  end

  // selected module answers with its own real slot number
  assign ioRdata = ioValid ? {16'h5a5a, 11'h000, ioRealSlot} : noise;
endmodule

// [bench/slot_remap_config_control_tb.sv]
// Purpose: self-checking bench for the slot remap loader
// Assumes: preset layout ends at slot 5
// Notes:   random maps from a fixed seed, corner records from a table
module slot_remap_config_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import slot_remap_pkg::*;

  logic        core_clk = 1'b0;
  logic        reset_n, remapEnable, commModulePresent;
  logic [4:0]  presetLastSlot, accCfgSlot, diagRealSlot;
  logic        startupRequest, startupEnd, recStart, recStrobe, recLast;
  logic [7:0]  recData;
  logic [15:0] recHwId, recStatus, st, hw;
  logic        recInStartup, recDone, loadRefused, running, ioInitialized;
  logic        stopLogged, memResetPulse, accValid, accWrite, accRecord;
  logic [31:0] accWdata, ioRdata, ioWdata, accRdata;
  logic        ioValid, accError, diagValid, diagOut, ctx;
  logic [4:0]  ioRealSlot, diagCfgSlot;
  logic [7:0]  cur[6];
  logic [7:0]  rec[$], r[$];
  logic [15:0] ev[7];
  int          fail_count, compares, stops, resets, k;

  slot_remap_config_control DUT (
    .core_clk(core_clk), .reset_n(reset_n), .remapEnable(remapEnable),
    .commModulePresent(commModulePresent), .presetLastSlot(presetLastSlot),
    .startupRequest(startupRequest), .startupEnd(startupEnd),
    .recStart(recStart), .recStrobe(recStrobe), .recLast(recLast),
    .recData(recData), .recHwId(recHwId), .recInStartup(recInStartup),
    .recDone(recDone), .recStatus(recStatus), .loadRefused(loadRefused),
    .running(running), .ioInitialized(ioInitialized),
    .stopLogged(stopLogged), .memResetPulse(memResetPulse),
    .accValid(accValid), .accCfgSlot(accCfgSlot), .accWrite(accWrite),
    .accRecord(accRecord), .accWdata(accWdata), .ioRdata(ioRdata),
    .ioValid(ioValid), .ioRealSlot(ioRealSlot), .ioWdata(ioWdata),
    .accRdata(accRdata), .accError(accError), .diagValid(diagValid),
    .diagRealSlot(diagRealSlot), .diagOut(diagOut),
    .diagCfgSlot(diagCfgSlot)
  );

  io_rack_model rack (
    .core_clk(core_clk), .ioValid(ioValid), .ioRealSlot(ioRealSlot),
    .ioRdata(ioRdata)
  );

  // ==========================================================================
  // clock and pulse counters
  always #2 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (stopLogged === 1'b1) stops++;
    if (memResetPulse === 1'b1) resets++;
  end

  // ==========================================================================
  // helpers
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask

  task automatic summarize();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // random map: slot 0 and 1 fixed, others distinct or absent
  // real slots distinct
  task automatic mkRec();
    k = $urandom % 6;
    cur[0] = 8'h00;
    cur[1] = 8'h01;
    for (int s = 2; s < 6; s++)
      cur[s] = ($urandom % 3 == 0) ? 8'hff : 8'(2 + (s - 2 + k) % 6);
    rec = {8'd11, REC_ID, REC_VERSION, REC_PAD};
    foreach (cur[s]) rec.push_back(cur[s]);
    rec.push_back(8'h09); // beyond the preset layout
  endtask

  // startup request (e=0) or end of startup program (e=1)
  task automatic ph(input bit e);
    if (e)
      startupEnd <= 1'b1;
    else
      startupRequest <= 1'b1;
    @(posedge core_clk);
    startupEnd <= 1'b0;
    startupRequest <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  // whole record write; status dead when no completion arrives
  task automatic record_write_instruction(input logic [7:0] b[$], input logic [15:0] h,
                       input logic c, output logic [15:0] s);
    int n;
    recHwId <= h;
    recInStartup <= c;
    recStart <= 1'b1;
    @(posedge core_clk);
    recStart <= 1'b0;
    foreach (b[i]) begin
      recStrobe <= 1'b1;
      recData <= b[i];
      recLast <= (i == b.size() - 1);
      @(posedge core_clk);
    end
    recStrobe <= 1'b0;
    recLast <= 1'b0;
    n = 0;
    s = 16'hdead;
    while (recDone !== 1'b1 && n < 8) begin
      @(posedge core_clk);
      n++;
    end
    if (recDone === 1'b1) s = recStatus;
    @(posedge core_clk);
  endtask

  task automatic acc(input int s, input bit w, input bit rc);
    accValid <= 1'b1;
    accCfgSlot <= 5'(s);
    accWrite <= w;
    accRecord <= rc;
    accWdata <= $urandom;
    #1;
    chk("ioValid", cur[s] != 8'hff, ioValid);
    if (cur[s] != 8'hff) chk("ioRealSlot", cur[s], ioRealSlot);
    if (cur[s] != 8'hff) chk("ioWdata", accWdata, ioWdata);
    @(posedge core_clk);
    accValid <= 1'b0;
    #1;
    if (!w && !rc) chk("accRdata", (cur[s] == 8'hff) ? 32'h0 :
      {16'h5a5a, 11'h000, cur[s][4:0]}, accRdata);
    chk("accError", rc && !w && cur[s] == 8'hff, accError);
    @(posedge core_clk);
  endtask

  task automatic dg(input int rs);
    int c;
    c = -1;
    for (int s = 0; s < 6; s++) if (cur[s] == 8'(rs)) c = s;
    diagValid <= 1'b1;
    diagRealSlot <= 5'(rs);
    @(posedge core_clk);
    diagValid <= 1'b0;
    #1;
    chk("diagOut", c >= 0, diagOut);
    if (c >= 0) chk("diagCfgSlot", c, diagCfgSlot);
    @(posedge core_clk);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    {reset_n, commModulePresent, startupRequest, startupEnd} = '0;
    {recStart, recStrobe, recLast, recInStartup, recData} = '0;
    {accValid, accWrite, accRecord, accWdata, diagValid} = '0;
    {accCfgSlot, diagRealSlot} = '0;
    remapEnable = 1'b1;
    presetLastSlot = 5'd5;
    recHwId = TARGET_HW_ID;
    ev = '{ERR_LENGTH, ERR_PARAM, ERR_PARAM, ERR_PARAM, ERR_PARAM,
           ERR_CONTEXT, 16'hdead};
    void'($urandom(32'h9a9f39e6));
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    chk("recStatus", ERR_NONE, recStatus);
    mkRec();
    ph(0);
    ph(1);
    chk("running", 0, running);
    chk("ioInitialized", 0, ioInitialized);
    chk("stopLogged", 1, stops);
    ph(0);
    record_write_instruction(rec, TARGET_HW_ID, 1'b1, st);
    chk("recStatus", ERR_NONE, st);
    chk("memReset", 0, resets);
    for (int i = 0; i < 7; i++) begin
      r = rec;
      hw = TARGET_HW_ID;
      ctx = 1'b1;
      case (i)
        0: r[0] = r[0] + 8'h01;
        1: r[1] = 8'hc5;
        2: r[2] = 8'h05;
        3: r[5] = 8'h00;
        4: begin
          r[8] = 8'h03;
          r[9] = 8'h03;
        end
        5: ctx = 1'b0;
        default: hw = 16'h0022;
      endcase
      record_write_instruction(r, hw, ctx, st);
      chk("recStatus", ev[i], st);
    end
    r = rec[0:8];
    r[0] = 8'h09;
    record_write_instruction(r, TARGET_HW_ID, 1'b1, st);
    chk("shortRec", ERR_LENGTH, st);
    ph(1);
    chk("running", 1, running);
    chk("ioInitialized", 1, ioInitialized);
    for (int s = 0; s < 6; s++)
      for (int m = 0; m < 4; m++) acc(s, m[0], m[1]);
    repeat (20) acc($urandom % 6, $urandom % 2, $urandom % 2);
    for (int rs = 0; rs < 10; rs++) dg(rs);
    ph(0);
    cur[2] = (cur[2] == 8'hff) ? 8'(2 + k) : 8'hff;
    rec[6] = cur[2];
    record_write_instruction(rec, TARGET_HW_ID, 1'b1, st);
    chk("recStatus", ERR_NONE, st);
    chk("memReset", 1, resets);
    ph(1);
    acc(2, 1'b0, 1'b0);
    ph(0);
    ph(1);
    chk("running", 1, running);
    commModulePresent <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("loadRefused", 1, loadRefused);
    commModulePresent <= 1'b0;
    remapEnable <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("loadRefused", 0, loadRefused);
    record_write_instruction(rec, TARGET_HW_ID, 1'b1, st);
    chk("recStatus", ERR_NOT_ENABLE, st);
    summarize();
  end

  // watchdog, far beyond the expected run length
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    summarize();
  end
endmodule
